/* core/channel_main_control.sv */
/*
  per-channel gain ramp and main control registers for four channels,
  with the control behaviour they steer: gate alignment, ramp address,
  update strobes, flushing, draining, routing and output gating.
  assumes host pins and gate/update pins are asynchronous; fifo levels,
  sample ticks, internal gates and channel data come from core_clk logic.
*/
// Notes on behaviour
// - latency trim bit removes two edges from the gate delay path
// - latency bypass bit feeds the selected gate straight into the channel
// - ramp length field is the top gain ramp ram address
// - immediate bit clear: slave loads only on masked synchronous updates
// - immediate bit set: write loads slave after four clock synchronisation
// - ramp hold freezes ramp address, gives host the ramp ram
// - delay select inserts half coarse-sample delay after the filter
// - coefficient hold gives host the filter coefficient rams
// - gate internal bit selects internal gate, else external pin
// - almost empty when fifo level reaches threshold plus one
// - complex output makes channels 0 and 2 route imaginary sums
// - offline zeroes fifo reads, drains 24 samples, then flags drained
// - input enable gates hardware gate and hardware update inputs
// - output enable clear forces channel output data to zero
// - serial unit free bit keeps it running regardless of gate
// - gate rising edge flushes channel and ram unless flush disabled
// - parallel mode fifo overflow resets channel unless disabled
// - software enable rise flushes ram 16 clocks and does masked update
// - software enable level allows serial requests, low stops them
// - immediate mode low word write makes the slave load strobe
`timescale 1ns/1ps

module channel_main_control (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // host port pins
  input wire logic host_wr_n,
  input wire logic [5:0] host_addr,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  // channel pins
  input wire logic [3:0] gate_pin,
  input wire logic [3:0] hw_update_pin,
  // core-side channel inputs
  input wire logic [3:0] internal_gate,
  input wire logic [3:0] sample_tick,
  input wire logic parallel_mode,
  input wire logic [3:0] fifo_overflow,
  input wire logic [3:0][3:0] fifo_level,
  input wire logic [3:0][19:0] chan_data,
  // channel control outputs
  output upconv_ctrl_pkg::chan_status_type [3:0] chan_status
);

  // ==========================================================
  // pin synchronisers
  localparam int SYNC_WIDTH = 31;

  logic [SYNC_WIDTH-1:0] pins_sync;
  logic wr_n_s;
  logic [5:0] addr_s;
  logic [15:0] wdata_s;
  logic [3:0] gate_s;
  logic [3:0] upd_s;

  sync_pair #(.WIDTH(SYNC_WIDTH)) pin_sync_inst (
    .core_clk(core_clk),
    .reset(reset),
    .pin_in({host_wr_n, host_addr, host_wdata, gate_pin, hw_update_pin}),
    .pin_sync(pins_sync)
  );

  assign {wr_n_s, addr_s, wdata_s, gate_s, upd_s} = pins_sync;

  // ==========================================================
  // host register file
  logic wr_n_prev;
  logic [3:0][15:0] gain_ramp_settings;
  logic [3:0][15:0] channel_main_settings;
  logic [3:0][15:0] next_gain_ramp_settings;
  logic [3:0][15:0] next_channel_main_settings;
  logic [15:0] next_host_rdata;
  logic write_start;
  logic [3:0] low_word_write;

  always_comb
  begin
    next_gain_ramp_settings = gain_ramp_settings;
    next_channel_main_settings = channel_main_settings;
    write_start = wr_n_prev & ~wr_n_s;
    low_word_write = 4'h0;
    for (int c = 0; c < upconv_ctrl_pkg::CHANNELS; c++)
    begin
      if (write_start && addr_s[5:4] == 2'(c))
      begin
        if (addr_s[3:0] == upconv_ctrl_pkg::GAIN_RAMP_OFFSET)
          next_gain_ramp_settings[c] = wdata_s;
        if (addr_s[3:0] == upconv_ctrl_pkg::MAIN_SETTINGS_OFFSET)
          next_channel_main_settings[c] = wdata_s;
        if (addr_s[3:0] == upconv_ctrl_pkg::RATE_LOW_WORD_OFFSET ||
            addr_s[3:0] == upconv_ctrl_pkg::CARRIER_LOW_WORD_OFFSET)
          low_word_write[c] = 1'b1;
      end
    end
    case (addr_s[3:0])
      upconv_ctrl_pkg::GAIN_RAMP_OFFSET:
        next_host_rdata = gain_ramp_settings[addr_s[5:4]];
      upconv_ctrl_pkg::MAIN_SETTINGS_OFFSET:
        next_host_rdata = channel_main_settings[addr_s[5:4]];
      default:
        next_host_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      wr_n_prev <= 1'b0;
      host_rdata <= 16'h0000;
      for (int c = 0; c < upconv_ctrl_pkg::CHANNELS; c++)
      begin
        gain_ramp_settings[c] <= upconv_ctrl_pkg::GAIN_RAMP_RESET;
        channel_main_settings[c] <= upconv_ctrl_pkg::MAIN_SETTINGS_RESET;
      end
    end
    else
    begin
      wr_n_prev <= wr_n_s;
      host_rdata <= next_host_rdata;
      gain_ramp_settings <= next_gain_ramp_settings;
      channel_main_settings <= next_channel_main_settings;
    end
  end

  // ==========================================================
  // channel control state
  localparam int DEPTH = upconv_ctrl_pkg::GATE_ALIGN_DEPTH;
  localparam int TRIM = upconv_ctrl_pkg::GATE_TRIM_EDGES;

  logic [3:0][DEPTH-1:0] gate_pipe;
  logic [3:0][DEPTH-1:0] next_gate_pipe;
  logic [3:0] gate_prev;
  logic [3:0] next_gate_prev;
  logic [3:0] upd_prev;
  logic [3:0] next_upd_prev;
  logic [3:0] sw_prev;
  logic [3:0] next_sw_prev;
  logic [3:0][2:0] imm_count;
  logic [3:0][2:0] next_imm_count;
  logic [3:0][4:0] flush_count;
  logic [3:0][4:0] next_flush_count;
  logic [3:0][4:0] drain_count;
  logic [3:0][4:0] next_drain_count;
  upconv_ctrl_pkg::drain_state_type [3:0] drain_state;
  upconv_ctrl_pkg::drain_state_type [3:0] next_drain_state;
  upconv_ctrl_pkg::chan_status_type [3:0] next_chan_status;

  always_comb
  begin
    logic [15:0] g;
    logic [15:0] m;
    logic sel_gate;
    logic aligned;
    logic gate_rise;
    logic upd_rise;
    logic sw_rise;
    logic [6:0] addr;
    g = 16'h0000;
    m = 16'h0000;
    sel_gate = 1'b0;
    aligned = 1'b0;
    gate_rise = 1'b0;
    upd_rise = 1'b0;
    sw_rise = 1'b0;
    addr = 7'h00;
    next_gate_pipe = gate_pipe;
    next_gate_prev = gate_prev;
    next_upd_prev = upd_prev;
    next_sw_prev = sw_prev;
    next_imm_count = imm_count;
    next_flush_count = flush_count;
    next_drain_count = drain_count;
    next_drain_state = drain_state;
    next_chan_status = chan_status;
    for (int c = 0; c < upconv_ctrl_pkg::CHANNELS; c++)
    begin
      g = gain_ramp_settings[c];
      m = channel_main_settings[c];
      // gate source and alignment
      if (m[upconv_ctrl_pkg::GATE_INTERNAL_BIT])
        sel_gate = internal_gate[c];
      else
        sel_gate = gate_s[c] & m[upconv_ctrl_pkg::INPUT_EN_BIT];
      next_gate_pipe[c] = {gate_pipe[c][DEPTH-2:0], sel_gate};
      if (g[upconv_ctrl_pkg::LATENCY_BYPASS_BIT])
        aligned = sel_gate;
      else if (g[upconv_ctrl_pkg::LATENCY_TRIM_BIT])
        aligned = gate_pipe[c][DEPTH-1-TRIM];
      else
        aligned = gate_pipe[c][DEPTH-1];
      next_gate_prev[c] = aligned;
      gate_rise = aligned & ~gate_prev[c];
      next_upd_prev[c] = upd_s[c] & m[upconv_ctrl_pkg::INPUT_EN_BIT];
      upd_rise = next_upd_prev[c] & ~upd_prev[c];
      next_sw_prev[c] = m[upconv_ctrl_pkg::SW_TX_BIT];
      sw_rise = m[upconv_ctrl_pkg::SW_TX_BIT] & ~sw_prev[c];

      // slave load strobes
      next_chan_status[c].load_masked = sw_rise | upd_rise;
      next_chan_status[c].load_immediate = 1'b0;
      if (imm_count[c] != 3'h0)
      begin
        next_imm_count[c] = imm_count[c] - 3'h1;
        if (imm_count[c] == 3'h1)
          next_chan_status[c].load_immediate = 1'b1;
      end
      if (low_word_write[c] && m[upconv_ctrl_pkg::IMMEDIATE_BIT])
        next_imm_count[c] = upconv_ctrl_pkg::IMMEDIATE_SYNC_CLKS;

      // ram flush on software enable or gate rise
      if (flush_count[c] != 5'h00)
        next_flush_count[c] = flush_count[c] - 5'h01;
      next_chan_status[c].chan_flush = 1'b0;
      if (gate_rise && !m[upconv_ctrl_pkg::FLUSH_DISABLE_BIT])
      begin
        next_chan_status[c].chan_flush = 1'b1;
        next_flush_count[c] = upconv_ctrl_pkg::RAM_FLUSH_CLKS;
      end
      if (sw_rise)
        next_flush_count[c] = upconv_ctrl_pkg::RAM_FLUSH_CLKS;
      next_chan_status[c].ram_flush = next_flush_count[c] != 5'h00;

      // offline drain
      unique case (drain_state[c])
        upconv_ctrl_pkg::drain_idle:
        begin
          if (!m[upconv_ctrl_pkg::ONLINE_BIT])
          begin
            next_drain_state[c] = upconv_ctrl_pkg::drain_busy;
            next_drain_count[c] = 5'h00;
          end
        end
        upconv_ctrl_pkg::drain_busy:
        begin
          if (m[upconv_ctrl_pkg::ONLINE_BIT])
            next_drain_state[c] = upconv_ctrl_pkg::drain_idle;
          else if (sample_tick[c])
          begin
            next_drain_count[c] = drain_count[c] + 5'h01;
            if (next_drain_count[c] == upconv_ctrl_pkg::DRAIN_SAMPLES)
              next_drain_state[c] = upconv_ctrl_pkg::drain_done;
          end
        end
        upconv_ctrl_pkg::drain_done:
        begin
          if (m[upconv_ctrl_pkg::ONLINE_BIT])
            next_drain_state[c] = upconv_ctrl_pkg::drain_idle;
        end
        default:
          next_drain_state[c] = upconv_ctrl_pkg::drain_idle;
      endcase
      next_chan_status[c].fifo_rd_zero =
        ~m[upconv_ctrl_pkg::ONLINE_BIT];
      next_chan_status[c].channel_drained_flag =
        next_drain_state[c] == upconv_ctrl_pkg::drain_done;

      // gain ramp address, frozen while the host holds the ram
      addr = chan_status[c].ramp_addr;
      if (!m[upconv_ctrl_pkg::RAMP_HOLD_BIT])
      begin
        if (aligned && addr < g[upconv_ctrl_pkg::RAMP_LIMIT_MSB:0])
          addr = addr + 7'h01;
        else if (aligned && addr > g[upconv_ctrl_pkg::RAMP_LIMIT_MSB:0])
          addr = g[upconv_ctrl_pkg::RAMP_LIMIT_MSB:0];
        else if (!aligned && addr != 7'h00)
          addr = addr - 7'h01;
      end
      next_chan_status[c].ramp_addr = addr;
      next_chan_status[c].ramp_host_access =
        m[upconv_ctrl_pkg::RAMP_HOLD_BIT];

      // plain control decodes
      next_chan_status[c].gate = aligned;
      next_chan_status[c].sib_run =
        aligned | m[upconv_ctrl_pkg::SIB_FREE_BIT];
      next_chan_status[c].serial_req_en =
        m[upconv_ctrl_pkg::SW_TX_BIT];
      next_chan_status[c].coef_host_access =
        m[upconv_ctrl_pkg::COEF_HOLD_BIT];
      next_chan_status[c].delay_half =
        m[upconv_ctrl_pkg::DELAY_SELECT_BIT];
      next_chan_status[c].route_imag = (c == 0 || c == 2) &&
        m[upconv_ctrl_pkg::COMPLEX_OUT_BIT];
      next_chan_status[c].almost_empty = fifo_level[c] <=
        ({1'b0, m[upconv_ctrl_pkg::EMPTY_THR_MSB:
                  upconv_ctrl_pkg::EMPTY_THR_LSB]} + 4'h1);
      next_chan_status[c].chan_reset = parallel_mode & fifo_overflow[c] &
        ~m[upconv_ctrl_pkg::OVF_RESET_DISABLE_BIT];
      if (m[upconv_ctrl_pkg::OUTPUT_EN_BIT])
        next_chan_status[c].data_out = chan_data[c];
      else
        next_chan_status[c].data_out = 20'h00000;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      gate_pipe <= '0;
      gate_prev <= 4'h0;
      upd_prev <= 4'h0;
      sw_prev <= 4'h0;
      imm_count <= '0;
      flush_count <= '0;
      drain_count <= '0;
      chan_status <= '0;
      for (int c = 0; c < upconv_ctrl_pkg::CHANNELS; c++)
        drain_state[c] <= upconv_ctrl_pkg::drain_idle;
    end
    else
    begin
      gate_pipe <= next_gate_pipe;
      gate_prev <= next_gate_prev;
      upd_prev <= next_upd_prev;
      sw_prev <= next_sw_prev;
      imm_count <= next_imm_count;
      flush_count <= next_flush_count;
      drain_count <= next_drain_count;
      drain_state <= next_drain_state;
      chan_status <= next_chan_status;
    end
  end

endmodule

/* core/sync_pair.sv */
/*
  two-stage synchroniser for a bundle of pin inputs.
  assumes each bit is a slow level sampled on core_clk.
*/
`timescale 1ns/1ps

module sync_pair #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // pins in, synchronised out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      stage_one <= '0;
      pin_sync <= '0;
    end
    else
    begin
      stage_one <= pin_in;
      pin_sync <= stage_one;
    end
  end

endmodule

/* core/upconv_ctrl_pkg.sv */
/*
  constants, field positions and carrier types for the per-channel
  gain ramp and main control logic of the four-channel upconverter.
  assumes a 16-bit host port and one core clock.
*/
package upconv_ctrl_pkg;

  // ==========================================================
  // register map
  localparam int CHANNELS = 4;
  localparam logic [3:0] GAIN_RAMP_OFFSET = 4'hB;
  localparam logic [3:0] MAIN_SETTINGS_OFFSET = 4'hC;
  localparam logic [3:0] RATE_LOW_WORD_OFFSET = 4'h6;
  localparam logic [3:0] CARRIER_LOW_WORD_OFFSET = 4'h9;
  localparam logic [15:0] GAIN_RAMP_RESET = 16'h0000;
  localparam logic [15:0] MAIN_SETTINGS_RESET = 16'h0000;

  // ==========================================================
  // gain_ramp_settings fields
  localparam int LATENCY_BYPASS_BIT = 8;
  localparam int LATENCY_TRIM_BIT = 7;
  localparam int RAMP_LIMIT_MSB = 6;

  // ==========================================================
  // channel_main_settings fields
  localparam int IMMEDIATE_BIT = 15;
  localparam int RAMP_HOLD_BIT = 14;
  localparam int DELAY_SELECT_BIT = 13;
  localparam int COEF_HOLD_BIT = 12;
  localparam int GATE_INTERNAL_BIT = 11;
  localparam int EMPTY_THR_MSB = 10;
  localparam int EMPTY_THR_LSB = 8;
  localparam int COMPLEX_OUT_BIT = 7;
  localparam int ONLINE_BIT = 6;
  localparam int INPUT_EN_BIT = 5;
  localparam int OUTPUT_EN_BIT = 4;
  localparam int SIB_FREE_BIT = 3;
  localparam int FLUSH_DISABLE_BIT = 2;
  localparam int OVF_RESET_DISABLE_BIT = 1;
  localparam int SW_TX_BIT = 0;

  // ==========================================================
  // timing counts in core clocks or sample ticks
  localparam logic [2:0] IMMEDIATE_SYNC_CLKS = 3'h4;
  localparam logic [4:0] RAM_FLUSH_CLKS = 5'h10;
  localparam logic [4:0] DRAIN_SAMPLES = 5'h18;
  localparam int GATE_ALIGN_DEPTH = 4;
  localparam int GATE_TRIM_EDGES = 2;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    drain_idle = 2'b00,
    drain_busy = 2'b01,
    drain_done = 2'b10
  } drain_state_type;

  typedef struct packed {
    logic gate;
    logic sib_run;
    logic serial_req_en;
    logic ramp_host_access;
    logic coef_host_access;
    logic delay_half;
    logic route_imag;
    logic fifo_rd_zero;
    logic channel_drained_flag;
    logic almost_empty;
    logic ram_flush;
    logic chan_flush;
    logic chan_reset;
    logic load_masked;
    logic load_immediate;
    logic [6:0] ramp_addr;
    logic [19:0] data_out;
  } chan_status_type;

endpackage

/* tb/channel_main_control_monitor.sv */
/*
  checker for channel 0 control outputs and channel 1 and 3 routing, bound to the block.
  assumes the block's port names and one core clock domain.
*/
`timescale 1ns/1ps

module channel_main_control_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // watched ports
  input wire logic parallel_mode,
  input wire logic [3:0] fifo_overflow,
  input wire logic [3:0] sample_tick,
  input wire logic [3:0][19:0] chan_data,
  input wire upconv_ctrl_pkg::chan_status_type [3:0] chan_status
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // ============================================================
  // ticks seen while fifo reads are zeroed
  logic [5:0] tick_cnt;
  logic [5:0] next_tick_cnt;
  always_comb
  begin
    next_tick_cnt = tick_cnt;
    if (!chan_status[0].fifo_rd_zero)
      next_tick_cnt = 6'h00;
    else if (sample_tick[0] && tick_cnt != 6'h3F)
      next_tick_cnt = tick_cnt + 6'h01;
  end
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
      tick_cnt <= 6'h00;
    else
      tick_cnt <= next_tick_cnt;

  // ============================================================
  // properties
  property p_route;
    !chan_status[1].route_imag && !chan_status[3].route_imag;
  endproperty
  a_route: assert property (p_route)
    else $error("route_imag set on channel 1 or 3");

  property p_data;
    chan_status[0].data_out == 20'h00000 ||
      chan_status[0].data_out == $past(chan_data[0]);
  endproperty
  a_data: assert property (p_data)
    else $error("data_out neither zero nor channel data");

  property p_flush_len;
    $rose(chan_status[0].ram_flush) |-> chan_status[0].ram_flush[*8]
      ##1 chan_status[0].ram_flush[*8] ##1 !chan_status[0].ram_flush;
  endproperty
  a_flush_len: assert property (p_flush_len)
    else $error("ram_flush not 16 cycles");

  property p_masked;
    chan_status[0].load_masked |=> !chan_status[0].load_masked;
  endproperty
  a_masked: assert property (p_masked)
    else $error("load_masked longer than one cycle");

  property p_offline;
    $rose(chan_status[0].channel_drained_flag) |->
      chan_status[0].fifo_rd_zero;
  endproperty
  a_offline: assert property (p_offline)
    else $error("drained while on line");

  property p_drain_count;
    $rose(chan_status[0].channel_drained_flag) |->
      tick_cnt >= 6'h17 && tick_cnt <= 6'h19;
  endproperty
  a_drain_count: assert property (p_drain_count)
    else $error("drained after wrong tick count");

  property p_chan_reset;
    chan_status[0].chan_reset |-> $past(parallel_mode) &&
      $past(fifo_overflow[0]);
  endproperty
  a_chan_reset: assert property (p_chan_reset)
    else $error("chan_reset without parallel overflow");

  property p_hold;
    chan_status[0].ramp_host_access ##1 chan_status[0].ramp_host_access
      |-> $stable(chan_status[0].ramp_addr);
  endproperty
  a_hold: assert property (p_hold)
    else $error("ramp_addr moved during hold");

  c_drained: cover property ($rose(chan_status[0].channel_drained_flag));
  c_imm: cover property (chan_status[0].load_immediate);
  c_flush: cover property ($rose(chan_status[0].ram_flush));
endmodule

bind channel_main_control channel_main_control_monitor
  channel_main_control_monitor_inst (
  .core_clk(core_clk),
  .reset(reset),
  .parallel_mode(parallel_mode),
  .fifo_overflow(fifo_overflow),
  .sample_tick(sample_tick),
  .chan_data(chan_data),
  .chan_status(chan_status)
);

/* tb/tb_top.sv */
/*
  self-checking bench for the channel control block.
  assumes the host model drives the host pins and ticks every 4 clocks.
*/
`timescale 1ns/1ps

module tb_top;
  // ============================================================
  // signals and instances
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic host_wr_n;
  logic [5:0] host_addr;
  logic [15:0] host_wdata, host_rdata;
  logic [3:0] gate_pin = 4'h0, hw_update_pin = 4'h0;
  logic [3:0] internal_gate = 4'h0, sample_tick = 4'h0;
  logic [3:0] fifo_overflow = 4'h0;
  logic parallel_mode = 1'b0;
  logic [3:0][3:0] fifo_level = {4{4'h0}};
  logic [3:0][19:0] chan_data = {4{20'hABCDE}};
  upconv_ctrl_pkg::chan_status_type [3:0] chan_status;
  upconv_ctrl_pkg::chan_status_type s0;
  logic [1:0] tick_div = 2'h0;
  int err_total = 0, compares = 0, cycles = 0;
  int f, m, i, d, t, b, fl, n;
  assign s0 = chan_status[0];

  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    tick_div <= tick_div + 2'h1;
    sample_tick <= {4{tick_div == 2'h0}};
    cycles++;
    if (cycles == 30000)
    begin
      err_total++;
      results();
    end
  end

  channel_main_control channel_main_control_inst (.core_clk(core_clk),
    .reset(reset), .host_wr_n(host_wr_n), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata),
    .gate_pin(gate_pin), .hw_update_pin(hw_update_pin),
    .internal_gate(internal_gate), .sample_tick(sample_tick),
    .parallel_mode(parallel_mode), .fifo_overflow(fifo_overflow),
    .fifo_level(fifo_level), .chan_data(chan_data),
    .chan_status(chan_status));
  upconv_host_model upconv_host_model_inst (.core_clk(core_clk),
    .host_wr_n(host_wr_n), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata));

  // ============================================================
  // helpers
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string w, input logic [19:0] e,
    input logic [19:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    upconv_host_model_inst.write(a, v);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [15:0] e);
    logic [15:0] v;
    upconv_host_model_inst.read(a, v);
    chk("rdata", {4'h0, e}, {4'h0, v});
  endtask
  task automatic watch(input int k);
    f = 0;
    m = 0;
    i = 0;
    repeat (k)
    begin
      step(1);
      f += (s0.ram_flush === 1'b1);
      m += (s0.load_masked === 1'b1);
      i += (s0.load_immediate === 1'b1);
    end
  endtask
  task automatic lat(output int k);
    k = 0;
    fl = 0;
    gate_pin[0] = 1'b1;
    for (int c = 1; c <= 40; c++)
    begin
      step(1);
      if (k == 0 && s0.gate === 1'b1)
        k = c;
      fl += (s0.chan_flush === 1'b1);
    end
    gate_pin[0] = 1'b0;
    step(40);
  endtask

  // ============================================================
  // scenarios
  task automatic t_regs();
    rdchk(6'h0B, upconv_ctrl_pkg::GAIN_RAMP_RESET);
    rdchk(6'h0C, upconv_ctrl_pkg::MAIN_SETTINGS_RESET);
    wr(6'h1C, 16'h1234);
    rdchk(6'h1C, 16'h1234);
    rdchk(6'h0C, 16'h0000);
    wr(6'h03, 16'hFFFF);
    rdchk(6'h03, 16'h0000);
    $display("t_regs done");
  endtask

  task automatic t_bits();
    wr(6'h0C, 16'h70C0);
    wr(6'h2C, 16'h0080);
    wr(6'h1C, 16'h0080);
    step(4);
    chk("ctl", 20'h0001E, {15'h0, s0.ramp_host_access, s0.delay_half,
      s0.coef_host_access, s0.route_imag, s0.fifo_rd_zero});
    chk("route2", 20'h1, {19'h0, chan_status[2].route_imag});
    chk("route1", 20'h0, {19'h0, chan_status[1].route_imag});
    wr(6'h0C, 16'h0050);
    chk("out_on", 20'hABCDE, s0.data_out);
    wr(6'h0C, 16'h0040);
    chk("out_off", 20'h0, s0.data_out);
    $display("t_bits done");
  endtask

  task automatic t_swtx();
    fork
      wr(6'h0C, 16'h0041);
      watch(40);
    join
    chk("flush", 20'd16, f[19:0]);
    chk("masked", 20'd1, m[19:0]);
    chk("req_on", 20'h1, {19'h0, s0.serial_req_en});
    wr(6'h0C, 16'h0040);
    chk("req_off", 20'h0, {19'h0, s0.serial_req_en});
    $display("t_swtx done");
  endtask

  task automatic t_imm();
    wr(6'h0C, 16'h8040);
    fork
      wr(6'h06, 16'h1111);
      watch(30);
    join
    chk("imm6", 20'd1, i[19:0]);
    chk("imm_mask", 20'd0, m[19:0]);
    fork
      wr(6'h09, 16'h2222);
      watch(30);
    join
    chk("imm9", 20'd1, i[19:0]);
    wr(6'h0C, 16'h0040);
    fork
      wr(6'h09, 16'h3333);
      watch(30);
    join
    chk("no_imm", 20'd0, i[19:0]);
    $display("t_imm done");
  endtask

  task automatic t_gate();
    lat(n);
    chk("gate_off", 20'd0, n[19:0]);
    fork
      begin
        hw_update_pin[0] = 1'b1;
        step(8);
        hw_update_pin[0] = 1'b0;
      end
      watch(30);
    join
    chk("hw_off", 20'd0, m[19:0]);
    wr(6'h0C, 16'h0060);
    fork
      begin
        hw_update_pin[0] = 1'b1;
        step(8);
        hw_update_pin[0] = 1'b0;
      end
      watch(30);
    join
    chk("hw_on", 20'd1, m[19:0]);
    lat(d);
    chk("gflush", 20'd1, fl[19:0]);
    wr(6'h0B, 16'h0080);
    lat(t);
    chk("trim", 20'd2, 20'(d - t));
    wr(6'h0B, 16'h0100);
    lat(b);
    chk("bypass", 20'h1, {19'h0, b < t && b > 0});
    wr(6'h0C, 16'h0064);
    lat(n);
    chk("noflush", 20'd0, fl[19:0]);
    chan_data[0] = 20'h00000;
    wr(6'h0C, 16'h0068);
    chk("sib_free", 20'h1, {19'h0, s0.sib_run});
    wr(6'h0C, 16'h0060);
    chk("sib_gate", 20'h0, {19'h0, s0.sib_run});
    chan_data[0] = 20'hABCDE;
    wr(6'h0C, 16'h0840);
    internal_gate[0] = 1'b1;
    step(20);
    chk("int_gate", 20'h1, {19'h0, s0.gate});
    internal_gate[0] = 1'b0;
    step(20);
    $display("t_gate done");
  endtask

  task automatic t_ramp();
    wr(6'h0B, 16'h0005);
    wr(6'h0C, 16'h0060);
    gate_pin[0] = 1'b1;
    step(40);
    chk("ramp_top", 20'h5, {13'h0, s0.ramp_addr});
    wr(6'h0C, 16'h4060);
    gate_pin[0] = 1'b0;
    step(40);
    chk("ramp_hold", 20'h5, {13'h0, s0.ramp_addr});
    wr(6'h0C, 16'h0060);
    step(40);
    chk("ramp_down", 20'h0, {13'h0, s0.ramp_addr});
    $display("t_ramp done");
  endtask

  task automatic t_drain();
    wr(6'h0C, 16'h0040);
    step(10);
    chk("on_line", 20'h0, {19'h0, s0.channel_drained_flag});
    n = 0;
    fork
      wr(6'h0C, 16'h0000);
      for (int c = 0; c < 300 && s0.channel_drained_flag !== 1'b1; c++)
      begin
        step(1);
        n += (s0.fifo_rd_zero === 1'b1 && sample_tick[0] === 1'b1);
      end
    join
    chk("drain", 20'h1, {19'h0, n >= 23 && n <= 25});
    $display("t_drain done");
  endtask

  task automatic t_fifo();
    wr(6'h0C, 16'h0240);
    fifo_level[0] = 4'h3;
    step(3);
    chk("ae_3", 20'h1, {19'h0, s0.almost_empty});
    fifo_level[0] = 4'h4;
    step(3);
    chk("ae_4", 20'h0, {19'h0, s0.almost_empty});
    fifo_overflow[0] = 1'b1;
    step(3);
    chk("ovf_ser", 20'h0, {19'h0, s0.chan_reset});
    parallel_mode = 1'b1;
    step(3);
    chk("ovf_par", 20'h1, {19'h0, s0.chan_reset});
    wr(6'h0C, 16'h0242);
    chk("ovf_dis", 20'h0, {19'h0, s0.chan_reset});
    fifo_overflow[0] = 1'b0;
    parallel_mode = 1'b0;
    $display("t_fifo done");
  endtask

  // ============================================================
  // sequence and verdict
  task automatic results();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    step(6);
    reset = 1'b0;
    step(2);
    t_regs();
    t_bits();
    t_swtx();
    t_imm();
    t_gate();
    t_ramp();
    t_drain();
    t_fifo();
    results();
  end
endmodule

/* tb/upconv_host_model.sv */
/*
  host port model: writes and reads channel registers over the pins.
  assumes the block syncs its pins to core_clk in two stages.
*/
`timescale 1ns/1ps

module upconv_host_model (
  // clock
  input wire logic core_clk,
  // host pins
  output logic host_wr_n,
  output logic [5:0] host_addr,
  output logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata
);
  // ============================================================
  // bus tasks
  initial
  begin
    host_wr_n = 1'b1;
    host_addr = 6'h00;
    host_wdata = 16'h0000;
  end

  // strobe low 4 clocks, high 4 clocks; data inverted after the 4 high clocks
  task automatic write(input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    host_addr = a;
    host_wdata = d;
    host_wr_n = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    host_wr_n = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    host_wdata = ~d;
  endtask

  task automatic read(input logic [5:0] a, output logic [15:0] d);
    @(posedge core_clk);
    #1;
    host_addr = a;
    repeat (4) @(posedge core_clk);
    #1;
    d = host_rdata;
  endtask
endmodule
